// >>> verilog/npc_codec.sv
// payload builder and parser for packets 41 to 45
// Operation
// - orientation matrix packet is id 41, 36 bytes, read only
// - nine fp32 matrix elements row-major at offsets 0 to 32
// - angular velocity packet is id 42, 12 bytes, read only
// - angular velocity x, y, z fp32 at offsets 0, 4, 8
// - angular acceleration packet is id 43, 12 bytes, read only
// - angular acceleration x, y, z fp32 at offsets 0, 4, 8
// - position-velocity packet is id 44, 60 bytes, read and write
// - fp64 lat, lon, height at 0, 8, 16; fp32 velocities at 24-32
// - six fp32 deviations at offsets 36 to 56 in fixed order
// - position packet is id 45, 36 bytes, read and write
// - fp64 lat, lon, height at 0-16; fp32 deviations at 24-32
`timescale 1ns/100ps
module npc_codec
   import npc_pkg::*;
(
   // clock, reset, enable
   input  wire logic         clock_in,
   input  wire logic         nrst_in,
   input  wire logic         ce_in,
   // navigation values to send, flattened word arrays
   input  wire logic [287:0] orient_in,
   input  wire logic [95:0]  angvel_in,
   input  wire logic [95:0]  angacc_in,
   // read request
   input  wire logic         req_valid_in,
   input  wire logic [7:0]   req_id_in,
   // received packet stream
   input  wire logic         rx_start_in,
   input  wire logic [7:0]   rx_id_in,
   input  wire logic [7:0]   rx_len_in,
   input  wire logic         rx_valid_in,
   input  wire logic [7:0]   rx_byte_in,
   input  wire logic         rx_end_in,
   // transmit stream
   input  wire logic         tx_ready_in,
   output logic              tx_start_out,
   output logic [7:0]        tx_id_out,
   output logic [7:0]        tx_len_out,
   output logic              tx_valid_out,
   output logic [7:0]        tx_byte_out,
   output logic              tx_last_out,
   // accepted aiding payloads and drop flag
   output logic [479:0]      ext_pv_out,
   output logic              ext_pv_upd_out,
   output logic [287:0]      ext_pos_out,
   output logic              ext_pos_upd_out,
   output logic              rx_drop_out
);
   typedef enum logic [2:0] {
      NPC_IDLE = 3'b001,
      NPC_SEND = 3'b010,
      NPC_LAST = 3'b100
   } npc_tx_e;

   typedef struct packed {
      npc_tx_e      tx_state;
      logic [479:0] tx_buf;
      logic [5:0]   tx_cnt;
      logic         tx_start;
      logic [7:0]   tx_id;
      logic [7:0]   tx_len;
      logic         tx_valid;
      logic         tx_last;
      logic         rx_act;
      logic         rx_ok;
      logic [7:0]   rx_id;
      logic [5:0]   rx_cnt;
      logic [479:0] rx_buf;
      logic [479:0] pv;
      logic         pv_upd;
      logic [287:0] pos;
      logic         pos_upd;
      logic         drop;
   } npc_state_s;

   npc_state_s st_ff;
   npc_state_s nxt_st;
   logic       sd_ok [3];

   // expected length for an id, zero for ids outside this codec
   function automatic logic [7:0] npc_len(input logic [7:0] id);
      if (id == NPC_ID_ORIENT) npc_len = NPC_LEN_ORIENT;
      else if (id == NPC_ID_ANGVEL) npc_len = NPC_LEN_VEC3;
      else if (id == NPC_ID_ANGACC) npc_len = NPC_LEN_VEC3;
      else if (id == NPC_ID_EXTPV) npc_len = NPC_LEN_EXTPV;
      else if (id == NPC_ID_EXTPOS) npc_len = NPC_LEN_EXTPOS;
      else npc_len = NPC_BYTE_ZERO;
   endfunction

   function automatic logic npc_writable(input logic [7:0] id);
      npc_writable = (id == NPC_ID_EXTPV) || (id == NPC_ID_EXTPOS);
   endfunction

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_sd
         // deviation words of the position packet at 24, 28, 32
         npc_sd_check u_sd (
            .value_in     (st_ff.rx_buf[(NPC_POS_SD_OFS + 4*g)*8 +: 32]),
            .positive_out (sd_ok[g])
         );
      end
   endgenerate

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.tx_start = 1'b0;
      nxt_st.pv_upd = 1'b0;
      nxt_st.pos_upd = 1'b0;
      nxt_st.drop = 1'b0;
      // transmit: byte 0 of the buffer goes out first, little endian words
      case (st_ff.tx_state)
         NPC_IDLE:
         begin
            if (req_valid_in && (npc_len(req_id_in) != NPC_BYTE_ZERO))
            begin
               nxt_st.tx_id = req_id_in;
               nxt_st.tx_len = npc_len(req_id_in);
               nxt_st.tx_cnt = 6'(npc_len(req_id_in));
               nxt_st.tx_start = 1'b1;
               nxt_st.tx_valid = 1'b1;
               nxt_st.tx_last = 1'b0;
               nxt_st.tx_state = NPC_SEND;
               if (req_id_in == NPC_ID_ORIENT)
                  nxt_st.tx_buf = {192'h0, orient_in};
               else if (req_id_in == NPC_ID_ANGVEL)
                  nxt_st.tx_buf = {384'h0, angvel_in};
               else if (req_id_in == NPC_ID_ANGACC)
                  nxt_st.tx_buf = {384'h0, angacc_in};
               else if (req_id_in == NPC_ID_EXTPV)
                  nxt_st.tx_buf = st_ff.pv;
               else
                  nxt_st.tx_buf = {192'h0, st_ff.pos};
            end
         end
         NPC_SEND:
         begin
            if (tx_ready_in)
            begin
               nxt_st.tx_buf = {8'h00, st_ff.tx_buf[479:8]};
               nxt_st.tx_cnt = st_ff.tx_cnt - 6'h01;
               if (st_ff.tx_cnt == 6'h02)
               begin
                  nxt_st.tx_last = 1'b1;
                  nxt_st.tx_state = NPC_LAST;
               end
            end
         end
         NPC_LAST:
         begin
            if (tx_ready_in)
            begin
               nxt_st.tx_valid = 1'b0;
               nxt_st.tx_last = 1'b0;
               nxt_st.tx_state = NPC_IDLE;
            end
         end
         default:
            nxt_st.tx_state = NPC_IDLE;
      endcase
      // receive
      if (rx_start_in)
      begin
         nxt_st.rx_act = 1'b1;
         nxt_st.rx_id = rx_id_in;
         nxt_st.rx_cnt = 6'h00;
         nxt_st.rx_ok = npc_writable(rx_id_in)
                        && (rx_len_in == npc_len(rx_id_in));
         nxt_st.drop = (npc_len(rx_id_in) != NPC_BYTE_ZERO) && !nxt_st.rx_ok;
      end
      else if (st_ff.rx_act && rx_valid_in)
      begin
         nxt_st.rx_buf[st_ff.rx_cnt*8 +: 8] = rx_byte_in;
         if (st_ff.rx_cnt != 6'h3f)
            nxt_st.rx_cnt = st_ff.rx_cnt + 6'h01;
         if (st_ff.rx_cnt >= 6'(npc_len(st_ff.rx_id)))
            nxt_st.rx_ok = 1'b0;
      end
      else if (st_ff.rx_act && rx_end_in)
      begin
         nxt_st.rx_act = 1'b0;
         if (st_ff.rx_ok && (st_ff.rx_cnt == 6'(npc_len(st_ff.rx_id))))
         begin
            if (st_ff.rx_id == NPC_ID_EXTPV)
            begin
               nxt_st.pv = st_ff.rx_buf;
               nxt_st.pv_upd = 1'b1;
            end
            else if (sd_ok[0] && sd_ok[1] && sd_ok[2])
            begin
               nxt_st.pos = st_ff.rx_buf[287:0];
               nxt_st.pos_upd = 1'b1;
            end
            else
               nxt_st.drop = 1'b1;
         end
         else if (npc_len(st_ff.rx_id) != NPC_BYTE_ZERO)
            nxt_st.drop = 1'b1;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (!nrst_in)
      begin
         st_ff <= '0;
         st_ff.tx_state <= NPC_IDLE;
      end
      else if (ce_in)
         st_ff <= nxt_st;
   end

   assign tx_start_out    = st_ff.tx_start;
   assign tx_id_out       = st_ff.tx_id;
   assign tx_len_out      = st_ff.tx_len;
   assign tx_valid_out    = st_ff.tx_valid;
   assign tx_byte_out     = st_ff.tx_buf[7:0];
   assign tx_last_out     = st_ff.tx_last;
   assign ext_pv_out      = st_ff.pv;
   assign ext_pv_upd_out  = st_ff.pv_upd;
   assign ext_pos_out     = st_ff.pos;
   assign ext_pos_upd_out = st_ff.pos_upd;
   assign rx_drop_out     = st_ff.drop;

   orient_len_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      tx_start_out && tx_id_out == NPC_ID_ORIENT |-> tx_len_out == NPC_LEN_ORIENT)
      else $error("orientation length wrong");
   angvel_len_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      tx_start_out && tx_id_out == NPC_ID_ANGVEL |-> tx_len_out == NPC_LEN_VEC3)
      else $error("angular velocity length wrong");
   angacc_len_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      tx_start_out && tx_id_out == NPC_ID_ANGACC |-> tx_len_out == NPC_LEN_VEC3)
      else $error("angular acceleration length wrong");
   orient_first_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && st_ff.tx_state == NPC_IDLE && req_valid_in && req_id_in == NPC_ID_ORIENT
      |=> tx_byte_out == $past(orient_in[7:0]))
      else $error("orientation first byte wrong");
   vel_first_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && st_ff.tx_state == NPC_IDLE && req_valid_in && req_id_in == NPC_ID_ANGVEL
      |=> tx_byte_out == $past(angvel_in[7:0]))
      else $error("angular velocity first byte wrong");
   acc_first_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && st_ff.tx_state == NPC_IDLE && req_valid_in && req_id_in == NPC_ID_ANGACC
      |=> tx_byte_out == $past(angacc_in[7:0]))
      else $error("angular acceleration first byte wrong");
   pv_update_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ext_pv_upd_out |-> $past(st_ff.rx_id) == NPC_ID_EXTPV
      && $past(st_ff.rx_cnt) == NPC_PV_BYTES)
      else $error("position velocity update without full payload");
   pos_sd_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ext_pos_upd_out |-> !ext_pos_out[NPC_POS_SD_OFS*8 + 31]
      && ext_pos_out[NPC_POS_SD_OFS*8 +: 31] != 31'h0)
      else $error("position accepted with bad deviation");
   ro_drop_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && rx_start_in && rx_id_in == NPC_ID_ORIENT |=> rx_drop_out)
      else $error("write to read-only packet not dropped");
endmodule

// >>> verilog/npc_pkg.sv
// constants for the packet payload codec
package npc_pkg;
   localparam logic [7:0] NPC_ID_ORIENT   = 8'h29;
   localparam logic [7:0] NPC_ID_ANGVEL   = 8'h2a;
   localparam logic [7:0] NPC_ID_ANGACC   = 8'h2b;
   localparam logic [7:0] NPC_ID_EXTPV    = 8'h2c;
   localparam logic [7:0] NPC_ID_EXTPOS   = 8'h2d;
   localparam logic [7:0] NPC_LEN_ORIENT  = 8'h24;
   localparam logic [7:0] NPC_LEN_VEC3    = 8'h0c;
   localparam logic [7:0] NPC_LEN_EXTPV   = 8'h3c;
   localparam logic [7:0] NPC_LEN_EXTPOS  = 8'h24;
   localparam int         NPC_PV_BYTES    = 60;
   localparam int         NPC_POS_SD_OFS  = 24;
   localparam int         NPC_ORIENT_WDS  = 9;
   localparam int         NPC_VEC3_WDS    = 3;
   localparam logic [7:0] NPC_BYTE_ZERO   = 8'h00;
endpackage

// >>> verilog/npc_sd_check.sv
// checks that an fp32 standard deviation is strictly positive
`timescale 1ns/100ps
module npc_sd_check
   import npc_pkg::*;
(
   // value, little endian bytes already assembled
   input  wire logic [31:0] value_in,
   // result
   output logic             positive_out
);
   // sign clear and not zero; nan is rejected as well
   always_comb
   begin
      positive_out = !value_in[31] && (value_in[30:0] != 31'h0)
                     && !((value_in[30:23] == 8'hff) && (value_in[22:0] != 23'h0));
   end
endmodule

// >>> test/npc_host.sv
// host model: sends aiding packets and sinks the transmit stream
`timescale 1ns/100ps
module npc_host (
   // clock and stall mode
   input  wire logic       clock_in,
   input  wire logic       slow_in,
   // towards the codec
   output logic            tx_ready_out,
   output logic            rx_start_out,
   output logic [7:0]      rx_id_out,
   output logic [7:0]      rx_len_out,
   output logic            rx_valid_out,
   output logic [7:0]      rx_byte_out,
   output logic            rx_end_out
);
   initial
   begin
      {tx_ready_out, rx_start_out, rx_id_out, rx_len_out} = 18'h0;
      {rx_valid_out, rx_byte_out, rx_end_out} = 10'h0;
   end
   // a slow sink stalls at random, so the codec must hold each byte
   always @(posedge clock_in)
   begin
      #1;
      tx_ready_out = slow_in ? 1'($urandom_range(0, 1)) : 1'b1;
   end
   // header, then n payload bytes in offset order, then the closing pulse
   task automatic send(input logic [7:0] id, input logic [7:0] len,
                       input logic [479:0] d, input int n);
      @(posedge clock_in) #1;
      rx_start_out = 1'b1;
      rx_id_out    = id;
      rx_len_out   = len;
      for (int i = 0; i < n; i++)
      begin
         @(posedge clock_in) #1;
         rx_start_out = 1'b0;
         rx_valid_out = 1'b1;
         rx_byte_out  = d[i*8+:8];
      end
      @(posedge clock_in) #1;
      rx_valid_out = 1'b0;
      rx_byte_out  = ~rx_byte_out;  // stale data must not be mistaken for payload
      rx_end_out   = 1'b1;
      @(posedge clock_in) #1;
      rx_end_out   = 1'b0;
   endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the packet payload codec
`timescale 1ns/100ps
module testbench;
   import npc_pkg::*;
   logic clock_in = 1'b0, nrst_in = 1'b0, slow = 1'b0, req_valid_in = 1'b0;
   logic ce = 1'b1, ce_rand = 1'b0;
   logic [7:0] req_id_in = 8'h00;
   logic [287:0] orient_in = '0;
   logic [95:0] angvel_in = '0, angacc_in = '0;
   logic tx_ready_in, rx_start_in, rx_valid_in, rx_end_in, tx_start_out, tx_valid_out;
   logic tx_last_out, ext_pv_upd_out, ext_pos_upd_out, rx_drop_out;
   logic [7:0] rx_id_in, rx_len_in, rx_byte_in, tx_id_out, tx_len_out, tx_byte_out;
   logic [479:0] ext_pv_out, pv, pos;
   logic [287:0] ext_pos_out;
   logic [481:0] exp_rx[$];
   logic [15:0] exp_hdr[$];
   logic [8:0] exp_tx[$];
   int mismatches = 0, checks = 0;
   always #5 clock_in = ~clock_in;
   // random enable gaps only during reads, the host stream has no stall
   always @(posedge clock_in)
      #1 ce = ce_rand ? ($urandom_range(0, 3) != 0) : 1'b1;
   npc_codec i_dut (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(ce),
      .orient_in(orient_in), .angvel_in(angvel_in), .angacc_in(angacc_in),
      .req_valid_in(req_valid_in), .req_id_in(req_id_in), .rx_start_in(rx_start_in),
      .rx_id_in(rx_id_in), .rx_len_in(rx_len_in), .rx_valid_in(rx_valid_in),
      .rx_byte_in(rx_byte_in), .rx_end_in(rx_end_in), .tx_ready_in(tx_ready_in),
      .tx_start_out(tx_start_out), .tx_id_out(tx_id_out), .tx_len_out(tx_len_out),
      .tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out), .tx_last_out(tx_last_out),
      .ext_pv_out(ext_pv_out), .ext_pv_upd_out(ext_pv_upd_out), .ext_pos_out(ext_pos_out),
      .ext_pos_upd_out(ext_pos_upd_out), .rx_drop_out(rx_drop_out));
   npc_host i_host (.clock_in(clock_in), .slow_in(slow), .tx_ready_out(tx_ready_in),
      .rx_start_out(rx_start_in), .rx_id_out(rx_id_in), .rx_len_out(rx_len_in),
      .rx_valid_out(rx_valid_in), .rx_byte_out(rx_byte_in), .rx_end_out(rx_end_in));
   task automatic chk(input logic [481:0] seen, input logic [481:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // read request: note header and every byte, then wait for the stream to end
   task automatic rd(input logic [7:0] id, input logic [479:0] d, input int n);
      exp_hdr.push_back({id, 8'(n)});
      for (int i = 0; i < n; i++)
         exp_tx.push_back({i == n - 1, d[i*8+:8]});
      @(posedge clock_in) #1;
      req_valid_in = 1'b1;
      req_id_in    = id;
      // hold until taken: a disabled edge would lose a one-cycle request
      for (int k = 0; k < 600 && tx_start_out !== 1'b1; k++)
         @(posedge clock_in) #1;
      req_valid_in = 1'b0;
      for (int k = 0; k < 600 && (exp_tx.size() != 0 || tx_valid_out !== 1'b0); k++)
         @(posedge clock_in) #1;
      @(posedge clock_in);
   endtask
   function automatic logic [479:0] rnd();
      for (int i = 0; i < 15; i++)
         rnd[i*32+:32] = $urandom;
   endfunction
   always @(posedge clock_in)
      // frozen pulses stand until the next enabled edge, count them there only
      if (nrst_in === 1'b1 && ce === 1'b1)
      begin
         if (tx_start_out === 1'b1)
            chk({tx_id_out, tx_len_out}, exp_hdr.pop_front());
         if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1)
            chk({tx_last_out, tx_byte_out}, exp_tx.pop_front());
         if (ext_pv_upd_out === 1'b1)
            chk({2'h1, ext_pv_out}, exp_rx.pop_front());
         if (ext_pos_upd_out === 1'b1)
            chk({2'h2, 192'h0, ext_pos_out}, exp_rx.pop_front());
         if (rx_drop_out === 1'b1)
            chk({2'h3, 480'h0}, exp_rx.pop_front());
      end
   initial
   begin
      #200000;
      mismatches++;
      conclude();
   end
   initial
   begin
      void'($urandom(1503));
      repeat (16) @(posedge clock_in);
      #1 nrst_in = 1'b1;
      for (int s = 0; s < 2; s++)
      begin
         slow = s[0];
         ce_rand = s[0];
         pv = rnd();
         orient_in = pv[287:0];
         angvel_in = pv[383:288];
         angacc_in = pv[479:384];
         rd(NPC_ID_ORIENT, 480'(orient_in), 36);
         rd(NPC_ID_ANGVEL, 480'(angvel_in), 12);
         rd(NPC_ID_ANGACC, 480'(angacc_in), 12);
      end
      ce_rand = 1'b0;
      $display("test reads done");
      pv = rnd();
      exp_rx.push_back({2'h1, pv});
      i_host.send(NPC_ID_EXTPV, NPC_LEN_EXTPV, pv, 60);
      rd(NPC_ID_EXTPV, pv, 60);
      $display("test position-velocity done");
      pos = rnd();
      for (int i = 0; i < 3; i++)
         pos[192+i*32+:32] = {1'b0, 8'($urandom_range(1, 254)), 23'($urandom)};
      pos[479:288] = '0;
      exp_rx.push_back({2'h2, pos});
      i_host.send(NPC_ID_EXTPOS, NPC_LEN_EXTPOS, pos, 36);
      rd(NPC_ID_EXTPOS, pos, 36);
      $display("test position done");
      for (int b = 0; b < 2; b++)
      begin
         pv = pos;
         pv[224+b*32+:32] = b ? 32'hbf800000 : 32'h00000000;
         exp_rx.push_back({2'h3, 480'h0});
         i_host.send(NPC_ID_EXTPOS, NPC_LEN_EXTPOS, pv, 36);
      end
      repeat (2) exp_rx.push_back({2'h3, 480'h0});
      i_host.send(NPC_ID_ORIENT, NPC_LEN_ORIENT, rnd(), 36);
      repeat (2) exp_rx.push_back({2'h3, 480'h0});
      i_host.send(NPC_ID_EXTPV, NPC_LEN_EXTPOS, rnd(), 36);
      repeat (4) @(posedge clock_in);
      rd(NPC_ID_EXTPOS, pos, 36);
      chk(482'(exp_rx.size()), 482'h0);
      chk(482'(exp_tx.size() + exp_hdr.size()), 482'h0);
      $display("test drops done");
      @(posedge clock_in) #1;
      nrst_in = 1'b0;
      @(posedge clock_in) #1;
      nrst_in = 1'b1;
      chk({tx_valid_out, tx_start_out, ext_pv_out}, 482'h0);
      chk(482'(ext_pos_out), 482'h0);
      $display("test reset done");
      conclude();
   end
endmodule
